// >>> verilog/phrs_top.sv
// Top of the panel hardware reset sequencer.
`timescale 1ns/10ps
`default_nettype none
module phrs_top
  import phrs_pkg::*;
#(
  parameter int          CANCEL_CYCLES = CANCEL_CYC,
  parameter int          BLANK_CYCLES  = BLANK_CYC,
  parameter logic [63:0] NVM_CONTENT   = 64'h0000_0000_0000_0000
)(
  // Clock and reset
  input  wire logic       REF_CLK,
  input  wire logic       RST_B,
  // Reset pin from the host
  input  wire logic       HW_RESET_N,
  // Panel state input and status
  input  wire logic       AWAKE,
  output var  logic       DISPLAY_BLANK,
  output var  logic       IN_RESET,
  output var  logic       SETTINGS_VALID,
  output var  logic [7:0] COMMON_VOLTAGE_SETTING,
  output var  logic [7:0] ID_BYTE0,
  output var  logic [7:0] ID_BYTE1,
  output var  logic [7:0] ID_BYTE2
);

  // ---------------------------------------------------------------------------
  // Pin synchroniser and glitch filter
  // ---------------------------------------------------------------------------
  logic        sync1_reg;
  logic        sync2_reg;
  logic        filt_reg;
  logic [23:0] width_reg;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      sync1_reg <= 1'b1;
      sync2_reg <= 1'b1;
    end
    else
    begin
      sync1_reg <= HW_RESET_N;
      sync2_reg <= sync1_reg;
    end
  end

  // The filtered level only follows the pin after it has held a new level
  // for the accept time; shorter pulses of either polarity are dropped.
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      filt_reg  <= 1'b1;
      width_reg <= 24'h00_0000;
    end
    else if (sync2_reg == filt_reg)
      width_reg <= 24'h00_0000;
    else if (width_reg >= 24'(ACCEPT_CYC - 1))
    begin
      filt_reg  <= sync2_reg;
      width_reg <= 24'h00_0000;
    end
    else
      width_reg <= phrs_inc(width_reg);
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  phrs_state_t state_reg;
  logic [23:0] blank_cnt_reg;
  logic [23:0] since_rel_reg;
  logic [2:0]  load_idx_reg;
  logic        load_seen_reg;
  logic        was_awake_reg;
  logic        blank_done;
  phrs_nvm_if  nvm ();

  assign nvm.addr = load_idx_reg;

  // Blanking is over at once for a sleeping panel, after the timed sequence otherwise.
  assign blank_done = !was_awake_reg || blank_cnt_reg >= 24'(BLANK_CYCLES);

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      state_reg     <= ST_RUN;
      blank_cnt_reg <= 24'h00_0000;
      was_awake_reg <= 1'b0;
    end
    else
    begin
      // The blank timer runs from reset entry through release and reload, so a
      // long blanking sequence never holds back the settings reload, which must
      // finish inside the cancel interval.
      if (state_reg != ST_RUN && !blank_done)
        blank_cnt_reg <= phrs_inc(blank_cnt_reg);
      case (state_reg)
        ST_RUN:
          if (!filt_reg)
          begin
            state_reg     <= ST_HELD;
            was_awake_reg <= AWAKE;
            blank_cnt_reg <= 24'h00_0000;
          end
        // Blanking runs while the pin is low as well; only a panel that was awake
        // needs the timed sequence, a sleeping one is already dark.
        ST_HELD:
          if (filt_reg)
            state_reg <= ST_BLANK;
        // One settling cycle after the filtered release before the reload starts.
        ST_BLANK:
          if (!filt_reg)
            state_reg <= ST_HELD;
          else
            state_reg <= ST_LOAD;
        ST_LOAD:
          if (!filt_reg)
            state_reg <= ST_HELD;
          else if (load_seen_reg)
            state_reg <= ST_WAIT;
        // Leaving needs both the cancel time and the end of any blanking sequence.
        ST_WAIT:
          if (!filt_reg)
            state_reg <= ST_HELD;
          else if (since_rel_reg >= 24'(CANCEL_CYCLES - 1) && blank_done)
            state_reg <= ST_RUN;
        default:
          state_reg <= ST_RUN;
      endcase
    end
  end

  // Time since the filtered release, used to end the cancel interval.
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      since_rel_reg <= 24'h00_0000;
    else if (!filt_reg)
      since_rel_reg <= 24'h00_0000;
    else
      since_rel_reg <= phrs_inc(since_rel_reg);
  end

  // ---------------------------------------------------------------------------
  // Settings reload
  // ---------------------------------------------------------------------------
  // Read data lag the address by one cycle, so a byte is stored one cycle
  // after its index was presented.
  logic       load_act_reg;
  logic [2:0] load_dst_reg;

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      load_idx_reg  <= 3'h0;
      load_act_reg  <= 1'b0;
      load_dst_reg  <= 3'h0;
      load_seen_reg <= 1'b0;
    end
    else if (state_reg != ST_LOAD)
    begin
      load_idx_reg  <= 3'h0;
      load_act_reg  <= 1'b0;
      load_seen_reg <= 1'b0;
    end
    else
    begin
      load_act_reg <= 1'b1;
      load_dst_reg <= load_idx_reg;
      if (load_idx_reg != 3'(NVM_WORDS - 1))
        load_idx_reg <= load_idx_reg + 3'h1;
      if (load_act_reg && load_dst_reg == 3'(NVM_WORDS - 1))
        load_seen_reg <= 1'b1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      COMMON_VOLTAGE_SETTING <= COMMON_VOLTAGE_RST;
      ID_BYTE0               <= 8'h00;
      ID_BYTE1               <= 8'h00;
      ID_BYTE2               <= 8'h00;
    end
    else if (state_reg == ST_LOAD && load_act_reg && !load_seen_reg)
    begin
      case (load_dst_reg)
        3'h0:    ID_BYTE0 <= nvm.rdata;
        3'h1:    ID_BYTE1 <= nvm.rdata;
        3'h2:    ID_BYTE2 <= nvm.rdata;
        3'h3:    COMMON_VOLTAGE_SETTING <= nvm.rdata;
        default: ;
      endcase
    end
  end

  phrs_nvm #(
    .CONTENT (NVM_CONTENT)
  ) u_nvm (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .port  (nvm)
  );

  // ---------------------------------------------------------------------------
  // Status outputs
  // ---------------------------------------------------------------------------
  // Registered so the panel never sees a glitch on its blanking control.
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      DISPLAY_BLANK  <= 1'b1;
      IN_RESET       <= 1'b0;
      SETTINGS_VALID <= 1'b0;
    end
    else
    begin
      DISPLAY_BLANK  <= (state_reg != ST_RUN) || !filt_reg;
      IN_RESET       <= (state_reg != ST_RUN) || !filt_reg;
      SETTINGS_VALID <= (state_reg == ST_RUN && filt_reg) || state_reg == ST_WAIT;
    end
  end

endmodule // phrs_top
`default_nettype wire

// >>> verilog/phrs_pkg.sv
// Package with timing constants, states and helpers for the panel hardware reset sequencer.
// Behaviour
// - Low pulses on the reset pin shorter than 5 us are ignored, pulses longer than 9 us always reset, and those in between may start one.
// - High-going glitches during a valid reset pulse are filtered the same way and neither end nor restart the reset.
// - After each reset release the identification bytes and common voltage setting are reloaded from storage within the 5 ms reset cancel interval.
// - During reset the display is blanked, with a blanking sequence of at most 120 ms when the panel was awake, and the default condition follows.
package phrs_pkg;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_MHZ           = 50;
  localparam int REJECT_US         = 5;
  localparam int ACCEPT_US         = 9;
  localparam int CANCEL_MS         = 5;
  localparam int BLANK_MS          = 120;
  // Accept threshold sits between the reject and full-reset limits.
  localparam int ACCEPT_CYC        = ((REJECT_US + ACCEPT_US) * CLK_MHZ) / 2;
  localparam int CANCEL_CYC        = CANCEL_MS * 1000 * CLK_MHZ;
  localparam int BLANK_CYC         = BLANK_MS * 1000 * CLK_MHZ;
  localparam int NVM_WORDS         = 8;

  // ---------------------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------------------
  localparam logic [7:0] COMMON_VOLTAGE_RST = 8'h00;
  localparam logic       AWAKE_RST          = 1'b0;

  // ---------------------------------------------------------------------------
  // States, Gray along the usual path except the WAIT to RUN step
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN   = 3'b000,
    ST_HELD  = 3'b001,
    ST_BLANK = 3'b011,
    ST_LOAD  = 3'b010,
    ST_WAIT  = 3'b110
  } phrs_state_t;

  // Saturating increment of a 24-bit counter.
  function automatic logic [23:0] phrs_inc(input logic [23:0] v);
    phrs_inc = (v == 24'hFF_FFFF) ? v : v + 24'h00_0001;
  endfunction

endpackage

// >>> verilog/phrs_nvm_if.sv
// Interface between the sequencer and its settings store.
`timescale 1ns/10ps
`default_nettype none
interface phrs_nvm_if;
  logic [2:0] addr;
  logic [7:0] rdata;
  modport seq (output addr, input rdata);
  modport mem (input addr, output rdata);
endinterface
`default_nettype wire

// >>> verilog/phrs_nvm.sv
// Small settings store holding identification and voltage bytes.
`timescale 1ns/10ps
`default_nettype none
module phrs_nvm
  import phrs_pkg::*;
#(
  parameter logic [63:0] CONTENT = 64'h0000_0000_0000_0000 // Arbitrary default content.
)(
  // Clock and reset
  input wire logic  clk,
  input wire logic  rst_b,
  // Read port
  phrs_nvm_if.mem   port
);

  // Registered read data keeps the read path one cycle deep.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      port.rdata <= 8'h00;
    else
      port.rdata <= CONTENT[port.addr*8 +: 8];
  end

endmodule // phrs_nvm
`default_nettype wire

// >>> bench/phrs_host.sv
// Host model that drives the panel reset pin.
`timescale 1ns/10ps
`default_nettype none
module phrs_host (
  // Clock and pin
  input  wire logic clk,
  output var  logic hw_reset_n
);
  initial hw_reset_n = 1'b1;
  // One low pulse, then idle; entered and left on a falling edge.
  task automatic drive(input int lo, input int hi);
    hw_reset_n = 1'b0;
    repeat (lo) @(negedge clk);
    hw_reset_n = 1'b1;
    repeat (hi) @(negedge clk);
  endtask
endmodule // phrs_host
`default_nettype wire

// >>> bench/phrs_top_sva.sv
// Assertions on the ports of the panel reset sequencer.
`timescale 1ns/10ps
`default_nettype none
module phrs_top_sva #(
  parameter int CANCEL_CYCLES = 600
)(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic HW_RESET_N,
  input wire logic DISPLAY_BLANK,
  input wire logic IN_RESET,
  input wire logic SETTINGS_VALID
);
  logic [23:0] lo_cnt;
  logic [23:0] hi_cnt;
  // Run lengths of the raw pin; they stop at a ceiling so idles never wrap.
  always_ff @(posedge REF_CLK or negedge RST_B)
    if (!RST_B)
    begin
      lo_cnt <= '0;
      hi_cnt <= '0;
    end
    else
    begin
      lo_cnt <= HW_RESET_N ? '0 : lo_cnt + {23'd0, lo_cnt != '1};
      hi_cnt <= !HW_RESET_N ? '0 : hi_cnt + {23'd0, hi_cnt != '1};
    end
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  property p_reject; $rose(IN_RESET) |-> lo_cnt >= 24'd250; endproperty
  a_reject: assert property (p_reject) else $error("short pulse reset");
  property p_accept; lo_cnt == 24'd450 |-> ##[0:8] IN_RESET; endproperty
  a_accept: assert property (p_accept) else $error("long pulse ignored");
  property p_glitch; $fell(IN_RESET) |-> hi_cnt >= 24'd250; endproperty
  a_glitch: assert property (p_glitch) else $error("glitch ended reset");
  property p_load; $fell(IN_RESET) |-> SETTINGS_VALID; endproperty
  a_load: assert property (p_load) else $error("reset ended unloaded");
  property p_cancel;
    $rose(SETTINGS_VALID) |-> HW_RESET_N && int'(hi_cnt) <= CANCEL_CYCLES;
  endproperty
  a_cancel: assert property (p_cancel) else $error("reload late");
  property p_blank; IN_RESET |-> DISPLAY_BLANK; endproperty
  a_blank: assert property (p_blank) else $error("not blanked");
  property p_done; $fell(IN_RESET) |-> !DISPLAY_BLANK; endproperty
  a_done: assert property (p_done) else $error("still blank");
endmodule // phrs_top_sva
bind phrs_top phrs_top_sva #(.CANCEL_CYCLES(CANCEL_CYCLES)) phrs_top_sva_i (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .HW_RESET_N(HW_RESET_N),
  .DISPLAY_BLANK(DISPLAY_BLANK), .IN_RESET(IN_RESET), .SETTINGS_VALID(SETTINGS_VALID));
`default_nettype wire

// >>> bench/phrs_top_test.sv
// Self-checking bench for the panel reset sequencer.
`timescale 1ns/10ps
`default_nettype none
module phrs_top_test;
  logic       ref_clk = 1'b0;
  logic       rst_b   = 1'b0;
  logic       awake   = 1'b0;
  logic       hw_reset_n;
  logic       blank;
  logic       in_rst;
  logic       valid;
  logic       in_q = 1'b0;
  logic [7:0] common_voltage_setting;
  logic [7:0] id0;
  logic [7:0] id1;
  logic [7:0] id2;
  int         err_total = 0;
  int         tests_run = 0;
  int         rises = 0;
  int         run_len = 0;
  // A 20 ns clock.
  always #10 ref_clk = ~ref_clk;
  // Short counts keep the run brief; the load must still fit the cancel time.
  phrs_top #(.CANCEL_CYCLES(600), .BLANK_CYCLES(2000),
    .NVM_CONTENT(64'h8877_6655_4433_2211)) phrs_top_i (
    .REF_CLK(ref_clk), .RST_B(rst_b), .HW_RESET_N(hw_reset_n), .AWAKE(awake),
    .DISPLAY_BLANK(blank), .IN_RESET(in_rst), .SETTINGS_VALID(valid),
    .COMMON_VOLTAGE_SETTING(common_voltage_setting), .ID_BYTE0(id0), .ID_BYTE1(id1), .ID_BYTE2(id2));
  phrs_host phrs_host_i (.clk(ref_clk), .hw_reset_n(hw_reset_n));
  // Counts reset entries and the total cycles spent in reset since the last start.
  always @(posedge ref_clk)
  begin
    in_q <= in_rst;
    if (in_rst === 1'b1 && in_q !== 1'b1) rises <= rises + 1;
    if (in_rst === 1'b1) run_len <= run_len + 1;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    if (got !== exp) err_total++;
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // Bounded wait for the sequence to finish.
  task automatic wait_idle;
    int n;
    n = 0;
    while (in_rst !== 1'b0 && n < 5000)
    begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 5000) err_total++;
    if (n == 5000) conclude();
  endtask
  task automatic start(input logic aw);
    awake = aw;
    rises = 0;
    run_len = 0;
  endtask
  task automatic t_spike;
    start(1'b0);
    phrs_host_i.drive(240, 400);
    chk(8'(rises), 8'h00);
    $display("spike done");
  endtask
  task automatic t_sleep;
    start(1'b0);
    phrs_host_i.drive(460, 10);
    wait_idle();
    chk(8'(rises), 8'h01);
    chk(id0, 8'h11);
    chk(id1, 8'h22);
    chk(id2, 8'h33);
    chk(common_voltage_setting, 8'h44);
    chk({7'd0, valid}, 8'h01);
    chk({7'd0, blank}, 8'h00);
    chk({7'd0, run_len < 1990}, 8'h01);
    $display("sleep done");
  endtask
  task automatic t_glitch;
    start(1'b0);
    phrs_host_i.drive(500, 100);
    phrs_host_i.drive(300, 10);
    wait_idle();
    chk(8'(rises), 8'h01);
    $display("glitch done");
  endtask
  task automatic t_awake;
    start(1'b1);
    phrs_host_i.drive(500, 10);
    wait_idle();
    chk({7'd0, run_len >= 1990}, 8'h01);
    chk({7'd0, valid}, 8'h01);
    $display("awake done");
  endtask
  // Main sequence.
  initial
  begin
    repeat (16) @(negedge ref_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge ref_clk);
    t_spike();
    t_sleep();
    t_glitch();
    t_awake();
    conclude();
  end
endmodule // phrs_top_test
`default_nettype wire
